// ---- shared/timer_counter_core_map.svh ----
`ifndef TIMER_COUNTER_CORE_MAP_SVH
`define TIMER_COUNTER_CORE_MAP_SVH

// apb byte addresses
`define TCC_ADDR_WIDTH          8
`define TCC_OFF_STATUS_CONTROL  8'h00
`define TCC_OFF_COUNTER_HIGH    8'h04
`define TCC_OFF_COUNTER_LOW     8'h08
`define TCC_OFF_MODULO_HIGH     8'h10
`define TCC_OFF_MODULO_LOW      8'h14
`define TCC_OFF_SYSTEM_OPTION   8'h18

// status/control field positions
`define TCC_BIT_OVERFLOW_FLAG   7
`define TCC_BIT_OVF_IRQ_ENABLE  6
`define TCC_BIT_CENTER_PWM      5
`define TCC_CLKS_MSB            4
`define TCC_CLKS_LSB            3
`define TCC_PS_MSB              2
`define TCC_PS_LSB              0

// system option field positions
`define TCC_BIT_SLOW_OSC_ROUTE  0

// clock source encodings
`define TCC_CLKS_OFF            2'h0
`define TCC_CLKS_BUS            2'h1
`define TCC_CLKS_UNUSED         2'h2
`define TCC_CLKS_CRYSTAL        2'h3

// reset values and landmarks
`define TCC_RESET_BYTE          8'h00
`define TCC_RESET_WORD          16'h0000
`define TCC_COUNT_ZERO          16'h0000
`define TCC_COUNT_ONE           16'h0001
`define TCC_COUNT_FULL          16'hFFFF
`define TCC_RESET_CLKS          2'h0
`define TCC_RESET_PS            3'h0
`define TCC_PRESCALE_ZERO       7'h00
`define TCC_PRESCALE_ONE        7'h01
`define TCC_PRESCALE_STEP       7'h01
`define TCC_RDATA_ZERO          32'h0000_0000

`endif

// ---- shared/timer_counter_core_pkg.sv ----
package timer_counter_core_pkg;

    // coherent counter read tracking, one-hot
    typedef enum logic [2:0]
    {
        COH_IDLE    = 3'b001,
        COH_HELD_HI = 3'b010,
        COH_HELD_LO = 3'b100
    } coherency_state_t;

    // count direction in center-aligned operation
    typedef enum logic
    {
        DIR_UP   = 1'b0,
        DIR_DOWN = 1'b1
    } count_dir_t;

endpackage : timer_counter_core_pkg

// ---- verilog/timer_counter_core.sv ----
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
// Overview of operation
// [R1] source 00 off, 01 bus clock, 10 unused, 11 crystal clock
// [R2] prescaler divides the selected clock by two to the power of the field
// [R3] crystal clock synchronised into bus domain before prescaler
// [R4] up-count wraps to zero after modulo; center mode reverses down instead
// [R5] modulo of zero or all ones gives a free-running counter
// [R6] overflow flag sets on wrap to zero, or stepping down from modulo
// [R7] flag clears by read while set, then write 0; overflow restarts it
// [R8] interrupt request whenever flag and interrupt enable are both set
// [R9] center select forces center PWM; clear lets channels choose
// [R10] any write to either counter byte zeroes the counter, data ignored
// [R11] reading the counter never disturbs counting
// [R12] reading one counter byte holds both until the other byte is read
// [R13] holding buffer released by reset, counter write or status/control write
// [R14] debug halt freezes counter and holding buffer, reads included
// [R15] one modulo byte write suppresses overflow until the other byte
// [R16] reset clears flag, enable, center select, counter and modulo
// [R17] option bit routes channel 0 input from pin or slow oscillator
// [R18] while timer owns a pin, port data and direction do not affect it
// [R19] after reset timer disabled, pins general-purpose inputs, pullups off
// [R20] software rewrites modulo soon after overflow, or zeroes counter first
`include "timer_counter_core_map.svh"

module timer_counter_core
    import timer_counter_core_pkg::*;
#(
    parameter int SYNC_STAGES = 2
)
(
    input  wire logic                        clk_sys,
    input  wire logic                        reset,
    input  wire logic                        clk_en,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [`TCC_ADDR_WIDTH-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        crystal_derived_clock,
    input  wire logic                        debug_halt_state,
    input  wire logic                        slow_oscillator,
    input  wire logic                        timer_channel0_pin,
    output logic                             timer_channel0_input,
    output logic                             timer_owns_pins,
    output logic                             center_pwm_select,
    output logic      [15:0]                 counter_value,
    output logic                             overflow_irq
);

    initial
    begin
        if (SYNC_STAGES < 2)
            $error("SYNC_STAGES must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////////
    // register state

    logic                   overflow_flag;
    logic                   overflow_irq_enable;
    logic [1:0]             clock_source_select;
    logic [2:0]             prescale_select;
    logic                   slow_osc_channel_route;
    logic [7:0]             modulo_high_byte;
    logic [7:0]             modulo_low_byte;
    logic                   modulo_pending;
    logic                   clear_armed;
    logic [15:0]            counter;
    count_dir_t             count_dir;
    coherency_state_t       coh_state;
    logic [15:0]            read_buffer;
    logic [6:0]             prescale_count;
    logic [SYNC_STAGES-1:0] crystal_sync;
    logic                   crystal_prev;

    logic                   next_overflow_flag;
    logic                   next_overflow_irq_enable;
    logic                   next_center_pwm_select;
    logic [1:0]             next_clock_source_select;
    logic [2:0]             next_prescale_select;
    logic                   next_slow_osc_channel_route;
    logic [7:0]             next_modulo_high_byte;
    logic [7:0]             next_modulo_low_byte;
    logic                   next_modulo_pending;
    logic                   next_clear_armed;
    logic [15:0]            next_counter;
    count_dir_t             next_count_dir;
    coherency_state_t       next_coh_state;
    logic [15:0]            next_read_buffer;
    logic [6:0]             next_prescale_count;
    logic [31:0]            next_prdata;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    logic       setup_phase;
    logic       acc_done;
    logic       wr_stb;
    logic       rd_stb;
    logic       addr_mapped;
    logic [7:0] status_byte;
    logic [15:0] modulo_value;

    // zero wait; frozen block withholds pready
    assign pready      = clk_en;
    assign setup_phase = psel & ~penable;
    assign acc_done    = psel & penable & clk_en;
    assign wr_stb      = acc_done & pwrite;
    // read effects happen at the setup edge
    assign rd_stb      = setup_phase & ~pwrite & clk_en;

    // unmapped addresses error
    always_comb
    begin
        case (paddr)
            `TCC_OFF_STATUS_CONTROL,
            `TCC_OFF_COUNTER_HIGH,
            `TCC_OFF_COUNTER_LOW,
            `TCC_OFF_MODULO_HIGH,
            `TCC_OFF_MODULO_LOW,
            `TCC_OFF_SYSTEM_OPTION: addr_mapped = 1'b1;
            default:                addr_mapped = 1'b0;
        endcase
    end

    assign pslverr = psel & penable & ~addr_mapped;

    assign modulo_value = {modulo_high_byte, modulo_low_byte};

    always_comb
    begin
        status_byte                          = `TCC_RESET_BYTE;
        status_byte[`TCC_BIT_OVERFLOW_FLAG]  = overflow_flag;
        status_byte[`TCC_BIT_OVF_IRQ_ENABLE] = overflow_irq_enable;
        status_byte[`TCC_BIT_CENTER_PWM]     = center_pwm_select;
        status_byte[`TCC_CLKS_MSB:`TCC_CLKS_LSB] = clock_source_select;
        status_byte[`TCC_PS_MSB:`TCC_PS_LSB] = prescale_select;
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock source, synchroniser and prescaler

    logic       source_tick;
    logic       count_tick;
    logic       timer_enabled;
    logic [6:0] prescale_mask;
    logic       crystal_edge;

    // edge detect reads only the last stage
    assign crystal_edge  = crystal_sync[SYNC_STAGES-1] & ~crystal_prev;             // [R3]
    assign timer_enabled = (clock_source_select == `TCC_CLKS_BUS) ||
                           (clock_source_select == `TCC_CLKS_CRYSTAL);              // [R1]
    assign prescale_mask = 7'((`TCC_PRESCALE_ONE << prescale_select) - `TCC_PRESCALE_ONE);

    // source select; the unused code behaves as off
    always_comb
    begin
        case (clock_source_select)
            `TCC_CLKS_BUS:     source_tick = 1'b1;                                  // [R1]
            `TCC_CLKS_CRYSTAL: source_tick = crystal_edge;                          // [R1]
            default:           source_tick = 1'b0;
        endcase
    end

    // prescaler follows selection and sync
    assign count_tick = source_tick & ~debug_halt_state &
                        ((prescale_count & prescale_mask) == prescale_mask);       // [R2]

    always_comb
    begin
        next_prescale_count = prescale_count;
        if (!timer_enabled)
            next_prescale_count = `TCC_PRESCALE_ZERO;
        else if (source_tick && !debug_halt_state)
            next_prescale_count = prescale_count + `TCC_PRESCALE_STEP;               // [R2]
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            prescale_count <= `TCC_PRESCALE_ZERO;
            crystal_sync   <= '0;
            crystal_prev   <= 1'b0;
        end
        else if (clk_en)
        begin
            prescale_count <= next_prescale_count;
            crystal_sync   <= {crystal_sync[SYNC_STAGES-2:0], crystal_derived_clock}; // [R3]
            crystal_prev   <= crystal_sync[SYNC_STAGES-1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter step and overflow detection

    logic        free_running;
    logic [15:0] top_value;
    logic [15:0] stepped_counter;
    count_dir_t  stepped_dir;
    logic        overflow_event;

    assign free_running = (modulo_value == `TCC_COUNT_ZERO) ||
                          (modulo_value == `TCC_COUNT_FULL);                        // [R5]
    assign top_value    = free_running ? `TCC_COUNT_FULL : modulo_value;           // [R5]

    // step: wrap or reverse at top
    always_comb
    begin
        stepped_counter = counter;
        stepped_dir     = count_dir;
        overflow_event  = 1'b0;
        if (!center_pwm_select)
        begin
            stepped_dir = DIR_UP;
            if (counter == top_value)
            begin
                stepped_counter = `TCC_COUNT_ZERO;                                  // [R4]
                overflow_event  = 1'b1;                                             // [R6]
            end
            else
                stepped_counter = counter + `TCC_COUNT_ONE;
        end
        else if (count_dir == DIR_UP)
        begin
            if (counter == top_value)
            begin
                stepped_dir     = DIR_DOWN;                                         // [R4]
                stepped_counter = counter - `TCC_COUNT_ONE;
                overflow_event  = 1'b1;                                             // [R6]
            end
            else
                stepped_counter = counter + `TCC_COUNT_ONE;
        end
        else
        begin
            if (counter == `TCC_COUNT_ZERO)
            begin
                stepped_dir     = DIR_UP;
                stepped_counter = `TCC_COUNT_ONE;
            end
            else
                stepped_counter = counter - `TCC_COUNT_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // writes, read effects, flag, coherency

    logic overflow_set;
    logic wr_status;
    logic wr_counter;
    logic rd_counter_hi;
    logic rd_counter_lo;

    // a half-written modulo holds off both flag and interrupt
    assign overflow_set  = count_tick & overflow_event & ~modulo_pending;         // [R15]
    assign wr_status     = wr_stb && (paddr == `TCC_OFF_STATUS_CONTROL);
    assign wr_counter    = wr_stb && ((paddr == `TCC_OFF_COUNTER_HIGH) ||
                                      (paddr == `TCC_OFF_COUNTER_LOW));
    // halted reads leave the buffer alone
    assign rd_counter_hi = rd_stb && !debug_halt_state && (paddr == `TCC_OFF_COUNTER_HIGH); // [R14]
    assign rd_counter_lo = rd_stb && !debug_halt_state && (paddr == `TCC_OFF_COUNTER_LOW);  // [R14]

    always_comb
    begin
        next_overflow_flag          = overflow_flag;
        next_overflow_irq_enable    = overflow_irq_enable;
        next_center_pwm_select      = center_pwm_select;
        next_clock_source_select    = clock_source_select;
        next_prescale_select        = prescale_select;
        next_slow_osc_channel_route = slow_osc_channel_route;
        next_modulo_high_byte       = modulo_high_byte;
        next_modulo_low_byte        = modulo_low_byte;
        next_modulo_pending         = modulo_pending;
        next_clear_armed            = clear_armed;
        next_counter                = counter;
        next_count_dir              = count_dir;
        next_coh_state              = coh_state;
        next_read_buffer            = read_buffer;

        // reads never touch counting
        if (count_tick)
        begin
            next_counter   = stepped_counter;                                       // [R11]
            next_count_dir = stepped_dir;
        end

        // read while set arms the clear
        if (rd_stb && (paddr == `TCC_OFF_STATUS_CONTROL) && overflow_flag)
            next_clear_armed = 1'b1;                                                // [R7]

        if (wr_status)
        begin
            next_overflow_irq_enable = pwdata[`TCC_BIT_OVF_IRQ_ENABLE];
            next_center_pwm_select   = pwdata[`TCC_BIT_CENTER_PWM];                 // [R9]
            next_clock_source_select = pwdata[`TCC_CLKS_MSB:`TCC_CLKS_LSB];         // [R1]
            next_prescale_select     = pwdata[`TCC_PS_MSB:`TCC_PS_LSB];             // [R2]
            // 0 clears only when armed
            if (clear_armed && !pwdata[`TCC_BIT_OVERFLOW_FLAG])
                next_overflow_flag = 1'b0;                                          // [R7]
            next_clear_armed = 1'b0;
            next_coh_state   = COH_IDLE;                                            // [R13]
        end

        if (wr_stb && (paddr == `TCC_OFF_SYSTEM_OPTION))
            next_slow_osc_channel_route = pwdata[`TCC_BIT_SLOW_OSC_ROUTE];          // [R17]

        // each modulo byte toggles pending
        if (wr_stb && (paddr == `TCC_OFF_MODULO_HIGH))
        begin
            next_modulo_high_byte = pwdata[7:0];
            next_modulo_pending   = ~modulo_pending;                                // [R15]
        end
        if (wr_stb && (paddr == `TCC_OFF_MODULO_LOW))
        begin
            next_modulo_low_byte = pwdata[7:0];
            next_modulo_pending  = ~modulo_pending;                                 // [R15]
        end

        // counter write zeroes count, data ignored
        if (wr_counter)
        begin
            next_counter   = `TCC_COUNT_ZERO;                                       // [R10]
            next_count_dir = DIR_UP;
            next_coh_state = COH_IDLE;                                              // [R13]
        end

        // coherent byte pairing, either order
        case (coh_state)
            COH_IDLE:
            begin
                if (rd_counter_hi)
                begin
                    next_read_buffer = counter;                                     // [R12]
                    next_coh_state   = COH_HELD_HI;
                end
                else if (rd_counter_lo)
                begin
                    next_read_buffer = counter;                                     // [R12]
                    next_coh_state   = COH_HELD_LO;
                end
            end
            COH_HELD_HI:
            begin
                if (rd_counter_lo)
                    next_coh_state = COH_IDLE;                                      // [R12]
            end
            COH_HELD_LO:
            begin
                if (rd_counter_hi)
                    next_coh_state = COH_IDLE;                                      // [R12]
            end
            default:
                next_coh_state = COH_IDLE;
        endcase

        // new overflow beats the clear
        if (overflow_set)
        begin
            next_overflow_flag = 1'b1;                                              // [R6]
            next_clear_armed   = 1'b0;                                              // [R7]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data at setup

    logic [15:0] counter_view;

    // held buffer answers both bytes
    assign counter_view = (coh_state == COH_IDLE) ? counter : read_buffer;         // [R12]

    always_comb
    begin
        next_prdata = prdata;
        if (rd_stb)
        begin
            next_prdata = `TCC_RDATA_ZERO;
            case (paddr)
                `TCC_OFF_STATUS_CONTROL: next_prdata[7:0] = status_byte;
                `TCC_OFF_COUNTER_HIGH:   next_prdata[7:0] = counter_view[15:8];
                `TCC_OFF_COUNTER_LOW:    next_prdata[7:0] = counter_view[7:0];
                `TCC_OFF_MODULO_HIGH:    next_prdata[7:0] = modulo_high_byte;
                `TCC_OFF_MODULO_LOW:     next_prdata[7:0] = modulo_low_byte;
                `TCC_OFF_SYSTEM_OPTION:  next_prdata[`TCC_BIT_SLOW_OSC_ROUTE] = slow_osc_channel_route;
                default:                 next_prdata = `TCC_RDATA_ZERO;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state registers

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            overflow_flag          <= 1'b0;                                         // [R16]
            overflow_irq_enable    <= 1'b0;                                         // [R16]
            center_pwm_select      <= 1'b0;                                         // [R16]
            clock_source_select    <= `TCC_RESET_CLKS;                              // [R19]
            prescale_select        <= `TCC_RESET_PS;
            slow_osc_channel_route <= 1'b0;
            modulo_high_byte       <= `TCC_RESET_BYTE;                              // [R16]
            modulo_low_byte        <= `TCC_RESET_BYTE;                              // [R16]
            modulo_pending         <= 1'b0;
            clear_armed            <= 1'b0;
            counter                <= `TCC_RESET_WORD;                              // [R16]
            count_dir              <= DIR_UP;
            coh_state              <= COH_IDLE;                                     // [R13]
            read_buffer            <= `TCC_RESET_WORD;
            prdata                 <= `TCC_RDATA_ZERO;
        end
        else if (clk_en)
        begin
            overflow_flag          <= next_overflow_flag;
            overflow_irq_enable    <= next_overflow_irq_enable;
            center_pwm_select      <= next_center_pwm_select;
            clock_source_select    <= next_clock_source_select;
            prescale_select        <= next_prescale_select;
            slow_osc_channel_route <= next_slow_osc_channel_route;
            modulo_high_byte       <= next_modulo_high_byte;
            modulo_low_byte        <= next_modulo_low_byte;
            modulo_pending         <= next_modulo_pending;
            clear_armed            <= next_clear_armed;
            counter                <= next_counter;
            count_dir              <= next_count_dir;
            coh_state              <= next_coh_state;
            read_buffer            <= next_read_buffer;
            prdata                 <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign counter_value        = counter;
    assign overflow_irq         = overflow_flag & overflow_irq_enable;              // [R8]
    // ownership lets port logic ignore data/direction
    assign timer_owns_pins      = timer_enabled;                                    // [R18]
    assign timer_channel0_input = slow_osc_channel_route ? slow_oscillator
                                                         : timer_channel0_pin;      // [R17]

endmodule : timer_counter_core

// ---- dv/timer_counter_core_asserts.sv ----
`timescale 1ns/10ps
module timer_counter_core_asserts (
    input wire logic        clk_sys, reset, clk_en, psel, penable, pwrite, debug_halt_state,
    input wire logic [7:0]  paddr,
    input wire logic        timer_owns_pins, center_pwm_select, overflow_irq,
    input wire logic [15:0] counter_value
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic wr;
    logic cnt_wr;
    // counter writes may jump
    assign wr = psel && penable && pwrite && clk_en;
    assign cnt_wr = wr && (paddr == 8'h04 || paddr == 8'h08);
    ////////////////////////////////////////////////////////////////////////
    reset_clear_a: assert property ($fell(reset) |-> counter_value == 16'h0000 && !center_pwm_select && !overflow_irq)
        else $error("reset left state");
    halt_freeze_a: assert property (debug_halt_state && !cnt_wr |=> $stable(counter_value))
        else $error("moved in halt");
    cnt_zero_a: assert property (cnt_wr |=> counter_value == 16'h0000)
        else $error("write did not zero");
    off_hold_a: assert property (!timer_owns_pins && !cnt_wr |=> $stable(counter_value))
        else $error("moved with no clock");
    up_step_a: assert property (!center_pwm_select && !cnt_wr ##1 $changed(counter_value)
        |-> counter_value == $past(counter_value) + 16'h0001 || counter_value == 16'h0000)
        else $error("bad up count step");
    irq_rise_a: assert property ($rose(overflow_irq) && !$past(wr) && !$past(center_pwm_select)
        |-> counter_value == 16'h0000) else $error("overflow not at wrap");
    irq_fall_a: assert property ($fell(overflow_irq) |-> $past(wr))
        else $error("irq fell without write");
    center_src_a: assert property ($changed(center_pwm_select) |-> $past(wr) && $past(paddr) == 8'h00)
        else $error("center select moved alone");
    cover property ($rose(overflow_irq));
    cover property (center_pwm_select && $fell(counter_value[0]));
    cover property (debug_halt_state && timer_owns_pins);
endmodule : timer_counter_core_asserts

// ---- dv/tb.sv ----
`timescale 1ns/10ps
module tb;
    logic clk_sys = 1'b0, reset = 1'b1, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic crystal_derived_clock = 1'b0, debug_halt_state = 1'b0, slow_oscillator = 1'b0, timer_channel0_pin = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, timer_channel0_input, timer_owns_pins, center_pwm_select, overflow_irq;
    logic [15:0] counter_value, hold;
    logic [7:0] sc, rd, hb;
    int error_cnt = 0, compares = 0, seed = 32'h1D06E008, cnt, pre, mdl, top;
    bit dir, pend, arm, route, ovf, tick, sp, src;
    bit [1:0] sy;
    timer_counter_core u_timer_counter_core (.*);
    always #2 clk_sys = ~clk_sys;
    task automatic cmp(input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : cmp
    task automatic tally_and_finish;
        if (error_cnt == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // one bounded apb transfer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) error_cnt++;
        if (n >= 20) tally_and_finish();
        if (!w) cmp(prdata, rd);
        cmp(pslverr, !(a inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18}));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    ////////////////////////////////////////////////////////////////////////
    // model: compare, then reads, tick, writes
    always @(posedge clk_sys)
    begin
        {slow_oscillator, timer_channel0_pin, crystal_derived_clock} <= 3'($random(seed));
        if (reset) {cnt, pre, mdl, sc, hb, dir, pend, arm, route, sy, sp} = '0;
        else
        begin
            cmp(counter_value, cnt);
            cmp(overflow_irq, sc[7] & sc[6]);
            cmp(timer_channel0_input, route ? slow_oscillator : timer_channel0_pin);
            cmp(timer_owns_pins, sc[3]);
            cmp(center_pwm_select, sc[5]);
            if (clk_en && psel && !penable && !pwrite)
            begin
                rd = 8'h00;
                if (paddr == 8'h04 || paddr == 8'h08)
                begin
                    if (hb == 8'h00) hold = 16'(cnt);
                    rd = (paddr == 8'h04) ? hold[15:8] : hold[7:0];
                    hb = (hb == 8'h00) ? paddr : (hb == paddr ? hb : 8'h00);
                end
                else if (paddr == 8'h00) {rd, arm} = {sc, sc[7]};
                else if (paddr[4:3] == 2'h2) rd = paddr[2] ? mdl[7:0] : mdl[15:8];
                else if (paddr == 8'h18) rd = {7'h00, route};
            end
            top = (mdl == 0 || mdl == 16'hFFFF) ? 16'hFFFF : mdl;
            {tick, ovf} = 2'b00;
            src = sc[4:3] == 2'h1 || (sc[4:3] == 2'h3 && sy[1] && !sp);
            if (clk_en) {sp, sy} = {sy, crystal_derived_clock};
            if (!sc[3]) pre = 0;
            else if (clk_en && !debug_halt_state && src) {tick, pre} = {pre == (1 << sc[2:0]) - 1, pre + 1};
            if (tick) pre = 0;
            if (tick) ovf = (!sc[5] || !dir) && cnt == top;
            if (tick) dir = sc[5] && (ovf || (dir && cnt != 0));
            if (tick) cnt = (!sc[5] && ovf) ? 0 : (dir ? cnt - 1 : cnt + 1) & 16'hFFFF;
            if (clk_en && psel && penable && pwrite)
            begin
                if (paddr == 8'h00) {sc[7], sc[6:0], arm, hb} = {sc[7] & (pwdata[7] | !arm | ovf), pwdata[6:0], 9'h0};
                if (paddr == 8'h04 || paddr == 8'h08) {cnt, dir, hb} = '0;
                if (paddr == 8'h10 || paddr == 8'h14) pend = !pend;
                if (paddr == 8'h10) mdl[15:8] = pwdata[7:0];
                if (paddr == 8'h14) mdl[7:0] = pwdata[7:0];
                if (paddr == 8'h18) route = pwdata[0];
            end
            if (ovf) arm = 0;
            if (ovf && !pend) sc[7] = 1'b1;
        end
    end
    initial
    begin
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        apb(0, 8'h00, 0);
        apb(0, 8'h14, 0);
        apb(1, 8'h18, 1);
        apb(0, 8'h1C, 0);
        apb(1, 8'h10, 0);
        apb(1, 8'h14, 8'h10);
        apb(1, 8'h00, 8'h48);
        apb(1, 8'h08, 32'($random(seed)));
        repeat (30) @(posedge clk_sys);
        apb(0, 8'h08, 0);
        apb(0, 8'h04, 0);
        apb(1, 8'h00, 8'hC8);
        apb(0, 8'h00, 0);
        apb(1, 8'h00, 8'h48);
        apb(1, 8'h04, 0);
        apb(1, 8'h14, 8'h08);
        repeat (40) @(posedge clk_sys);
        apb(1, 8'h10, 0);
        apb(1, 8'h00, 8'h40);
        apb(1, 8'h00, 8'h4B);
        repeat (80) @(posedge clk_sys);
        debug_halt_state <= 1'b1;
        repeat (6) @(posedge clk_sys);
        clk_en <= 1'b0;
        repeat (4) @(posedge clk_sys);
        clk_en <= 1'b1;
        debug_halt_state <= 1'b0;
        apb(1, 8'h00, 8'h40);
        apb(1, 8'h04, 0);
        apb(1, 8'h00, 8'h68);
        repeat (10) @(posedge clk_sys);
        apb(1, 8'h00, 8'h40);
        apb(1, 8'h04, 0);
        apb(1, 8'h00, 8'h58);
        repeat (40) @(posedge clk_sys);
        apb(1, 8'h00, 8'h50);
        apb(1, 8'h10, 8'hFF);
        apb(1, 8'h14, 8'hFF);
        apb(1, 8'h00, 8'h48);
        repeat (65540) @(posedge clk_sys);
        tally_and_finish();
    end
endmodule : tb
bind timer_counter_core timer_counter_core_asserts u_timer_counter_core_asserts (.*);
